// ===== pic_pkg.sv
package pic_pkg;
   localparam int NUM_SLOTS = 13;
   localparam int NUM_GROUPS = 6;
   localparam int NUM_LEVELS = 4;
   localparam int LEVEL_W = 2;
   localparam int SLOT_W = 4;

   localparam logic [7:0] REG_IEN_FIRST = 8'ha8;
   localparam logic [7:0] REG_PRIO_LOW = 8'ha9;
   localparam logic [7:0] REG_IEN_SECOND = 8'hb8;
   localparam logic [7:0] REG_PRIO_HIGH = 8'hb9;
   localparam logic [7:0] REG_STATUS = 8'hc4;
   localparam logic [7:0] REG_FLAGS_LOW = 8'hc5;
   localparam logic [7:0] REG_FLAGS_HIGH = 8'hc6;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] PRIO_FIELD_MASK = 8'h3f;

   localparam int GLOBAL_EN_BIT = 7;
   localparam int RESERVED_FIRST_BIT = 5;
   localparam int SERIAL_EN_BIT = 4;
   localparam int KEY_EN_BIT = 2;
   localparam int TIMER_EN_BIT = 1;
   localparam int EXTERNAL_EN_BIT = 0;
   localparam int SPI_EN_BIT = 7;
   localparam int INFRARED_EN_BIT = 5;
   localparam int USB_EN_BIT = 4;
   localparam int RESERVED_SECOND_BIT = 3;
   localparam int SECOND_TW_EN_BIT = 2;
   localparam int FIRST_TW_EN_BIT = 1;
   localparam int CONVERTER_EN_BIT = 0;

   localparam int STATUS_CALL_BIT = 7;
   localparam int STATUS_ACTIVE_BIT = 6;
   localparam int FLAGS_HIGH_W = NUM_SLOTS - 8;

   localparam int DETECT_CYCLES = 1;
   localparam int LCALL_CYCLES = 6;
   localparam int MIN_LATENCY_CYCLES = DETECT_CYCLES + LCALL_CYCLES;
   localparam logic [2:0] CALL_LAST = 3'(LCALL_CYCLES - 1);

   typedef enum logic [1:0] {PIC_IDLE = 2'b01, PIC_CALL = 2'b10} pic_state_type;
   typedef logic [15:0] pic_addr_type;

   // Slot index is the polling position minus one
   localparam pic_addr_type VECTOR_TABLE [NUM_SLOTS] = '{16'h0003, 16'h0083, 16'h0043, 16'h000b, 16'h004b,
      16'h0013, 16'h0053, 16'h001b, 16'h002b, 16'h0023, 16'h0063, 16'h005b, 16'h006b};
   localparam logic [2:0] GROUP_TABLE [NUM_SLOTS] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3,
      3'h4, 3'h4, 3'h5, 3'h5};

   // Third reserved slot has no enable at all
   function automatic logic [NUM_SLOTS-1:0] pic_slot_enable(input logic [7:0] first, input logic [7:0] second);
      pic_slot_enable = {second[INFRARED_EN_BIT], 1'b0, second[USB_EN_BIT], first[SERIAL_EN_BIT],
         second[RESERVED_SECOND_BIT], first[RESERVED_FIRST_BIT], second[SECOND_TW_EN_BIT], first[KEY_EN_BIT],
         second[FIRST_TW_EN_BIT], first[TIMER_EN_BIT], second[CONVERTER_EN_BIT], second[SPI_EN_BIT],
         first[EXTERNAL_EN_BIT]};
   endfunction
endpackage

// ===== pic_core_if.sv
`timescale 1ns/1ps
interface pic_core_if;
   import pic_pkg::*;
   logic [NUM_SLOTS-1:0] pending;
   logic [NUM_SLOTS-1:0][LEVEL_W-1:0] slot_level;
   logic win_valid;
   logic [SLOT_W-1:0] win_slot;
   logic [LEVEL_W-1:0] win_level;
   logic push;
   logic [LEVEL_W-1:0] push_level;
   logic pop;
   logic active_valid;
   logic [LEVEL_W-1:0] active_level;
   logic [NUM_LEVELS-1:0] in_service;

   modport arb (input pending, slot_level, output win_valid, win_slot, win_level);
   modport arb_user (output pending, slot_level, input win_valid, win_slot, win_level);
   modport svc (input push, push_level, pop, output active_valid, active_level, in_service);
   modport svc_user (output push, push_level, pop, input active_valid, active_level, in_service);
endinterface

// ===== pic_arbiter.sv
`timescale 1ns/1ps
module pic_arbiter
   import pic_pkg::*;
(
   pic_core_if.arb arb
);
   logic found;
   logic [SLOT_W-1:0] slot;
   logic [LEVEL_W-1:0] level;

   always_comb begin
      found = 1'b0;
      slot = '0;
      level = '0;
      // Walking downward lets the earlier polling slot win a tie
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (arb.pending[i] && (!found || arb.slot_level[i] >= level)) begin
            found = 1'b1;
            slot = SLOT_W'(i);
            level = arb.slot_level[i];
         end
      end
   end

   assign arb.win_valid = found;
   assign arb.win_slot = slot;
   assign arb.win_level = level;
endmodule

// ===== pic_service_track.sv
`timescale 1ns/1ps
module pic_service_track
   import pic_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   pic_core_if.svc svc
);
   typedef struct packed {
      logic [NUM_LEVELS-1:0] in_service;
   } pic_svc_state_type;

   pic_svc_state_type st_reg;
   pic_svc_state_type st_next;
   logic [LEVEL_W-1:0] top;

   always_comb begin
      top = '0;
      for (int i = 0; i < NUM_LEVELS; i++) begin
         if (st_reg.in_service[i]) begin
            top = LEVEL_W'(i);
         end
      end
      st_next = st_reg;
      // Return unwinds only the highest active level
      if (svc.pop && (|st_reg.in_service)) begin
         st_next.in_service[top] = 1'b0;
      end
      if (svc.push) begin
         st_next.in_service[svc.push_level] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign svc.active_valid = |st_reg.in_service;
   assign svc.active_level = top;
   assign svc.in_service = st_reg.in_service;

   chk_push_marks_level: assert property (@(posedge core_clk) disable iff (!rst_n)
      svc.push |=> st_reg.in_service[$past(svc.push_level)])
      else $error("pushed service level not recorded");

   chk_pop_unwinds_top: assert property (@(posedge core_clk) disable iff (!rst_n)
      svc.pop && !svc.push && svc.active_valid
      |=> st_reg.in_service == ($past(st_reg.in_service) & ~(4'h1 << $past(top))))
      else $error("return did not clear only the top level");
endmodule

// ===== pic_controller.sv
`timescale 1ns/1ps
// Behaviour
// - Thirteen slots, ten sources, four levels.
// - Flags set regardless of enable bits.
// - Accepted request forces call next cycle.
// - Each slot vectors to its fixed address.
// - Only strictly higher level preempts service.
// - Return ends the active service level.
// - Latency: one detect plus six call cycles.
// - Six groups share priority settings.
// - Equal levels resolved by polling order.
// - High and low bits encode level.
// - Group n uses bit n of both.
// - Global enable gates every acknowledge.
// - First register enables serial, key, timer, external.
// - Second register enables remaining six sources.
module pic_controller
   import pic_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [NUM_SLOTS-1:0] src_event,
   input wire logic cpu_insn_boundary,
   input wire logic cpu_reti,
   output logic force_lcall,
   output logic [15:0] lcall_vector,
   output logic irq_ack
);
   typedef struct packed {
      pic_state_type state;
      logic [7:0] ien_first;
      logic [7:0] ien_second;
      logic [7:0] prio_low;
      logic [7:0] prio_high;
      logic [NUM_SLOTS-1:0] flags;
      logic [2:0] call_cnt;
      pic_addr_type vector;
      logic [SLOT_W-1:0] ack_slot;
      logic ack;
      logic [7:0] rdata;
   } pic_ctl_state_type;

   pic_ctl_state_type r_reg;
   pic_ctl_state_type r_next;

   pic_core_if cif ();

   logic [NUM_SLOTS-1:0] slot_en;
   logic global_en;
   logic take;
   logic accept;
   logic [NUM_SLOTS-1:0] clr_mask;
   logic [NUM_SLOTS-1:0] ack_mask;
   logic [7:0] status_byte;
   logic arb_miss;

   // Reserved slots only see requests if software breaks the zero-bit convention
   assign slot_en = pic_slot_enable(r_reg.ien_first, r_reg.ien_second);
   assign global_en = r_reg.ien_first[GLOBAL_EN_BIT];
   assign cif.pending = r_reg.flags & slot_en & {NUM_SLOTS{global_en}};

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_slot_level
         // Slots of one group always share a level
         assign cif.slot_level[g] = {r_reg.prio_high[GROUP_TABLE[g]], r_reg.prio_low[GROUP_TABLE[g]]};
      end
   endgenerate

   pic_arbiter u_arbiter (
      .arb (cif.arb)
   );

   pic_service_track u_service (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .svc (cif.svc)
   );

   // A return in the same cycle is served first so the stack never pushes and pops at once
   assign take = cif.win_valid && (!cif.active_valid || (cif.win_level > cif.active_level)) && !cpu_reti;
   assign accept = (r_reg.state == PIC_IDLE) && take && cpu_insn_boundary;

   assign cif.push = accept;
   assign cif.push_level = cif.win_level;
   assign cif.pop = cpu_reti;

   assign ack_mask = accept ? (NUM_SLOTS'(1) << cif.win_slot) : '0;

   always_comb begin
      clr_mask = '0;
      if (reg_wr && (reg_addr == REG_FLAGS_LOW)) begin
         clr_mask[7:0] = reg_wdata;
      end else if (reg_wr && (reg_addr == REG_FLAGS_HIGH)) begin
         clr_mask[NUM_SLOTS-1:8] = reg_wdata[FLAGS_HIGH_W-1:0];
      end
   end

   always_comb begin
      status_byte = '0;
      status_byte[STATUS_CALL_BIT] = (r_reg.state == PIC_CALL);
      status_byte[STATUS_ACTIVE_BIT] = cif.active_valid;
      status_byte[5:4] = cif.active_level;
      status_byte[3:0] = r_reg.ack_slot;
   end

   always_comb begin
      r_next = r_reg;
      r_next.ack = 1'b0;
      r_next.rdata = '0;

      if (reg_wr) begin
         if (reg_addr == REG_IEN_FIRST) begin
            r_next.ien_first = reg_wdata;
         end else if (reg_addr == REG_IEN_SECOND) begin
            r_next.ien_second = reg_wdata;
         end else if (reg_addr == REG_PRIO_LOW) begin
            r_next.prio_low = reg_wdata & PRIO_FIELD_MASK;
         end else if (reg_addr == REG_PRIO_HIGH) begin
            r_next.prio_high = reg_wdata & PRIO_FIELD_MASK;
         end
      end

      if (reg_rd) begin
         if (reg_addr == REG_IEN_FIRST) begin
            r_next.rdata = r_reg.ien_first;
         end else if (reg_addr == REG_IEN_SECOND) begin
            r_next.rdata = r_reg.ien_second;
         end else if (reg_addr == REG_PRIO_LOW) begin
            r_next.rdata = r_reg.prio_low;
         end else if (reg_addr == REG_PRIO_HIGH) begin
            r_next.rdata = r_reg.prio_high;
         end else if (reg_addr == REG_STATUS) begin
            r_next.rdata = status_byte;
         end else if (reg_addr == REG_FLAGS_LOW) begin
            r_next.rdata = r_reg.flags[7:0];
         end else if (reg_addr == REG_FLAGS_HIGH) begin
            r_next.rdata = {{(8 - FLAGS_HIGH_W){1'b0}}, r_reg.flags[NUM_SLOTS-1:8]};
         end
      end

      // New events win over both software and acknowledge clears
      r_next.flags = (r_reg.flags & ~clr_mask & ~ack_mask) | src_event;

      case (r_reg.state)
         PIC_IDLE: begin
            if (accept) begin
               r_next.state = PIC_CALL;
               r_next.call_cnt = CALL_LAST;
               r_next.vector = VECTOR_TABLE[cif.win_slot];
               r_next.ack_slot = cif.win_slot;
               r_next.ack = 1'b1;
            end
         end
         PIC_CALL: begin
            // Held for the whole forced call, the core fetches nothing else
            if (r_reg.call_cnt == 3'h0) begin
               r_next.state = PIC_IDLE;
            end else begin
               r_next.call_cnt = r_reg.call_cnt - 3'h1;
            end
         end
         default: begin
            r_next.state = PIC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg.state <= PIC_IDLE;
         r_reg.ien_first <= REG_RESET;
         r_reg.ien_second <= REG_RESET;
         r_reg.prio_low <= REG_RESET;
         r_reg.prio_high <= REG_RESET;
         r_reg.flags <= '0;
         r_reg.call_cnt <= 3'h0;
         r_reg.vector <= 16'h0000;
         r_reg.ack_slot <= 4'h0;
         r_reg.ack <= 1'b0;
         r_reg.rdata <= 8'h00;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;
   assign force_lcall = (r_reg.state == PIC_CALL);
   assign lcall_vector = r_reg.vector;
   assign irq_ack = r_reg.ack;

   // Assertion helper: any pending slot the arbiter should have preferred
   always_comb begin
      arb_miss = 1'b0;
      for (int j = 0; j < NUM_SLOTS; j++) begin
         if (cif.pending[j] && (cif.slot_level[j] > cif.win_level)) begin
            arb_miss = 1'b1;
         end
         if (cif.pending[j] && (cif.slot_level[j] == cif.win_level) && (SLOT_W'(j) < cif.win_slot)) begin
            arb_miss = 1'b1;
         end
      end
   end

   chk_flag_captures_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (|src_event) |=> ((r_reg.flags & $past(src_event)) == $past(src_event)))
      else $error("event lost in flag register");

   chk_ack_vector_slot: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack |-> force_lcall && (lcall_vector == VECTOR_TABLE[r_reg.ack_slot]))
      else $error("acknowledge without matching vector");

   chk_call_six_cycles: assert property (@(posedge core_clk) disable iff (!rst_n)
      cif.push |=> force_lcall [*6] ##1 !force_lcall)
      else $error("forced call not six cycles long");

   chk_ack_follows_detect: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept |=> irq_ack ##1 !irq_ack)
      else $error("acknowledge not one cycle after detection");

   chk_global_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      !global_en |-> ##1 !irq_ack)
      else $error("acknowledge while globally disabled");

   chk_pending_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack |-> (|($past(r_reg.flags & slot_en) & (13'h0001 << r_reg.ack_slot))) && $past(global_en))
      else $error("acknowledged slot was not pending and enabled");

   chk_poll_order: assert property (@(posedge core_clk) disable iff (!rst_n)
      cif.win_valid |-> !arb_miss)
      else $error("arbiter skipped a higher or earlier request");

   chk_strict_preempt: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack && $past(cif.active_valid) |-> $past(cif.win_level) > $past(cif.active_level))
      else $error("preempted by equal or lower level");

   chk_reti_no_push: assert property (@(posedge core_clk) disable iff (!rst_n)
      cpu_reti |-> !cif.push)
      else $error("push collided with return");

   chk_ack_marks_service: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept |=> cif.active_valid && (cif.active_level >= $past(cif.win_level)))
      else $error("accepted level not in service");

   chk_flag_cleared_on_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack && (($past(src_event) & (13'h0001 << r_reg.ack_slot)) == 13'h0000) |-> !r_reg.flags[r_reg.ack_slot])
      else $error("acknowledged flag still set");

   // Register access checks
   chk_rdata_read_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      !reg_rd
      |=> reg_rdata == 8'h00)
      else $error("read data outside the read slot");

   chk_first_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && (reg_addr == REG_IEN_FIRST)
      |=> r_reg.ien_first == $past(reg_wdata))
      else $error("first enable write lost");

   chk_second_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && (reg_addr == REG_IEN_SECOND)
      |=> r_reg.ien_second == $past(reg_wdata))
      else $error("second enable write lost");

   chk_prio_low_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && (reg_addr == REG_PRIO_LOW)
      |=> (r_reg.prio_low[5:0] == $past(reg_wdata[5:0])) && (r_reg.prio_low[7:6] == 2'b00))
      else $error("low priority bits stored wrongly");

   chk_prio_high_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && (reg_addr == REG_PRIO_HIGH)
      |=> (r_reg.prio_high[5:0] == $past(reg_wdata[5:0])) && (r_reg.prio_high[7:6] == 2'b00))
      else $error("high priority bits stored wrongly");

   chk_flag_write_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr && (reg_addr == REG_FLAGS_LOW) && !(|src_event[7:0])
      |=> (r_reg.flags[7:0] & $past(reg_wdata)) == 8'h00)
      else $error("written flag bits not cleared");

   chk_flag_only_by_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(|src_event)
      |=> (r_reg.flags & ~$past(r_reg.flags)) == 13'h0000)
      else $error("flag set without an event");

   // Call sequencing checks
   chk_no_push_in_call: assert property (@(posedge core_clk) disable iff (!rst_n)
      force_lcall
      |-> !cif.push)
      else $error("accept during a forced call");

   chk_vector_held: assert property (@(posedge core_clk) disable iff (!rst_n)
      force_lcall && !irq_ack
      |-> $stable(lcall_vector))
      else $error("vector changed inside a forced call");

   chk_spare_slot_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      cif.win_valid
      |-> !cif.pending[11])
      else $error("slot without enable became pending");

   chk_ack_needs_boundary: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack
      |-> $past(cpu_insn_boundary) && !$past(cpu_reti))
      else $error("acknowledge outside an instruction boundary");

   chk_ack_from_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_ack
      |-> $past(r_reg.state) == PIC_IDLE)
      else $error("acknowledge while a call was running");

   chk_call_count_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      force_lcall
      |-> r_reg.call_cnt <= CALL_LAST)
      else $error("call counter out of range");

   chk_call_ends_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      force_lcall && (r_reg.call_cnt == 3'h0)
      |=> !force_lcall)
      else $error("forced call overran its last cycle");

   chk_global_blocks_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
      !global_en
      |-> cif.pending == 13'h0000)
      else $error("request pending while globally disabled");

   chk_push_strictly_higher: assert property (@(posedge core_clk) disable iff (!rst_n)
      cif.push
      |-> !cif.active_valid || (cif.push_level > cif.active_level))
      else $error("pushed level not above active level");

   chk_state_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
      1'b1
      |-> $onehot(r_reg.state))
      else $error("call state not one-hot");
endmodule

// ===== pic_cpu_model.sv
`timescale 1ns/1ps
module pic_cpu_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic force_lcall,
   input wire logic slow,
   input wire logic reti_req,
   output logic cpu_insn_boundary,
   output logic cpu_reti
);
   logic [1:0] phase_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 2'h0;
         cpu_insn_boundary <= 1'b0;
         cpu_reti <= 1'b0;
      end else begin
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
         // Busy stacking the return address while a call runs
         cpu_insn_boundary <= !force_lcall && (!slow || phase_reg == 2'h0);
         // Return whenever requested, with no boundary check, never inside a call
         cpu_reti <= reti_req && !force_lcall;
      end
   end
endmodule

// ===== priority_interrupt_controller_tb_top.sv
`timescale 1ns/1ps
module priority_interrupt_controller_tb_top;
   import pic_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [12:0] src_event = 13'h0000;
   logic cpu_insn_boundary;
   logic cpu_reti;
   logic force_lcall;
   logic [15:0] lcall_vector;
   logic irq_ack;
   logic slow = 1'b0;
   logic reti_req = 1'b0;
   // Own copies, so a wrong table in the design shows up
   localparam logic [15:0] EXP_VEC [13] = '{16'h0003, 16'h0083, 16'h0043, 16'h000b, 16'h004b, 16'h0013,
      16'h0053, 16'h001b, 16'h002b, 16'h0023, 16'h0063, 16'h005b, 16'h006b};
   localparam int GRP_OF [13] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5};
   localparam logic [12:0] LEGAL = 13'h167f;
   int err_total = 0;
   int num_checks = 0;
   int seed = 32'h6f78;
   logic [7:0] rdat;
   logic [15:0] vec;
   logic got;
   logic [7:0] lo;
   logic [7:0] hi;
   logic [12:0] m;
   int w;
   int cnt;

   always #50 core_clk = ~core_clk;

   pic_controller u_pic_controller (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
      .cpu_insn_boundary(cpu_insn_boundary), .cpu_reti(cpu_reti), .force_lcall(force_lcall),
      .lcall_vector(lcall_vector), .irq_ack(irq_ack));
   pic_cpu_model u_pic_cpu_model (.core_clk(core_clk), .rst_n(rst_n), .force_lcall(force_lcall), .slow(slow),
      .reti_req(reti_req), .cpu_insn_boundary(cpu_insn_boundary), .cpu_reti(cpu_reti));

   function automatic int lvl(int s, logic [7:0] l, logic [7:0] h);
      return {h[GRP_OF[s]], l[GRP_OF[s]]};
   endfunction

   // Strict compare keeps the lowest slot on a tie
   function automatic int winner(logic [12:0] mk, logic [7:0] l, logic [7:0] h);
      int best;
      best = -1;
      for (int s = 0; s < 13; s++) begin
         if (mk[s] && (best < 0 || lvl(s, l, h) > lvl(best, l, h))) best = s;
      end
      return best;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rdat = reg_rdata;
   endtask

   task automatic fire(input logic [12:0] mk);
      @(posedge core_clk);
      src_event <= mk;
      @(posedge core_clk);
      src_event <= 13'h0000;
   endtask

   task automatic do_return();
      @(posedge core_clk);
      reti_req <= 1'b1;
      @(posedge core_clk);
      reti_req <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // Bounded wait; lets the whole call finish when one is seen
   task automatic wait_ack(output logic g);
      g = 1'b0;
      for (int n = 0; n < 40 && !g; n++) begin
         @(negedge core_clk);
         if (irq_ack === 1'b1) g = 1'b1;
      end
      vec = lcall_vector;
      if (g) repeat (7) @(negedge core_clk);
   endtask

   initial begin
      #(100 * 60000);
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      logic [7:0] adr [6];
      logic [7:0] wv [6];
      logic [7:0] ev [6];
      adr = '{REG_IEN_FIRST, REG_PRIO_LOW, REG_IEN_SECOND, REG_PRIO_HIGH, REG_STATUS, 8'h55};
      wv = '{8'hd7, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hff};
      ev = '{8'hd7, 8'h3f, 8'hf7, 8'h3f, 8'h00, 8'h00};
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(adr[i]);
         check(rdat, 8'h00);
         wr(adr[i], wv[i]);
         rd(adr[i]);
         check(rdat, ev[i]);
      end
      $display("test registers done");
      wr(REG_IEN_FIRST, 8'h00);
      wr(REG_IEN_SECOND, 8'h00);
      wr(REG_PRIO_LOW, 8'h00);
      wr(REG_PRIO_HIGH, 8'h00);
      fire(13'h0001);
      rd(REG_FLAGS_LOW);
      check(rdat, 8'h01);
      wr(REG_IEN_FIRST, 8'h80);
      wait_ack(got);
      check(got, 1'b0);
      wr(REG_IEN_FIRST, 8'h01);
      wait_ack(got);
      check(got, 1'b0);
      wr(REG_IEN_FIRST, 8'h81);
      wait_ack(got);
      check(got, 1'b1);
      check(vec, 16'h0003);
      rd(REG_FLAGS_LOW);
      check(rdat, 8'h00);
      do_return();
      fire(13'h0008);
      rd(REG_FLAGS_LOW);
      check(rdat, 8'h08);
      wr(REG_FLAGS_LOW, 8'h08);
      rd(REG_FLAGS_LOW);
      check(rdat, 8'h00);
      $display("test gating done");
      // Reserved enable bits stay zero
      wr(REG_IEN_FIRST, 8'h97);
      wr(REG_IEN_SECOND, 8'hb7);
      for (int s = 0; s < 13; s++) begin
         if (LEGAL[s]) begin
            fire(13'h0001 << s);
            @(negedge core_clk);
            check(irq_ack, 1'b0);
            @(negedge core_clk);
            check(irq_ack, 1'b1);
            check(lcall_vector, EXP_VEC[s]);
            cnt = 0;
            repeat (8) begin
               if (force_lcall === 1'b1) cnt++;
               @(negedge core_clk);
            end
            check(16'(cnt), 16'd6);
            rd(REG_STATUS);
            check(rdat, {4'h4, 4'(s)});
            do_return();
         end
      end
      fire(13'h0980);
      wait_ack(got);
      check(got, 1'b0);
      rd(REG_FLAGS_LOW);
      check(rdat, 8'h80);
      rd(REG_FLAGS_HIGH);
      check(rdat, 8'h09);
      wr(REG_FLAGS_LOW, 8'hff);
      wr(REG_FLAGS_HIGH, 8'h1f);
      $display("test vectors done");
      wr(REG_PRIO_LOW, 8'h01);
      wr(REG_PRIO_HIGH, 8'h10);
      fire(13'h0008);
      wait_ack(got);
      check(vec, 16'h000b);
      fire(13'h0001);
      wait_ack(got);
      check(vec, 16'h0003);
      fire(13'h0004);
      wait_ack(got);
      check(got, 1'b0);
      fire(13'h0200);
      wait_ack(got);
      check(vec, 16'h0023);
      rd(REG_STATUS);
      check(rdat, 8'h69);
      do_return();
      wait_ack(got);
      check(got, 1'b0);
      do_return();
      wait_ack(got);
      check(got, 1'b1);
      check(vec, 16'h0043);
      do_return();
      do_return();
      rd(REG_STATUS);
      check(rdat, 8'h02);
      $display("test nesting done");
      for (int it = 0; it < 25; it++) begin
         lo = (it == 0) ? 8'h00 : 8'($random(seed)) & 8'h3f;
         hi = (it == 0) ? 8'h00 : 8'($random(seed)) & 8'h3f;
         m = (it == 0) ? LEGAL : 13'($random(seed)) & LEGAL;
         slow <= 1'($random(seed));
         wr(REG_PRIO_LOW, lo);
         wr(REG_PRIO_HIGH, hi);
         fire(m);
         while (m != 13'h0000) begin
            w = winner(m, lo, hi);
            wait_ack(got);
            check(got, 1'b1);
            check(vec, EXP_VEC[w]);
            m[w] = 1'b0;
            do_return();
         end
      end
      slow <= 1'b0;
      $display("test random done");
      complete_run();
   end
endmodule
